// ### dv/bsr_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
module bsr_core_bench;
  import bsr_pkg::*;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, wr_ready_i = 1'b0, hold = 1'b0, flush = 1'b0;
  logic kt, kc, okt, okc, ld_n, rnw, oe_n, wv, rreq, ovf;
  logic [15:0] addr, ra;
  logic [3:0] sel_n;
  logic [35:0] dq_w, dq_r, rd;
  bsr_wbeat_type wb, e;
  bsr_wbeat_type exp[$];
  int err_total = 0, checks = 0, ndrain = 0;

  // Array model and expectations
  function automatic logic [35:0] rdp(input logic [15:0] a);
    return {a[3:0], a, ~a};
  endfunction : rdp
  function automatic logic [15:0] bx(input logic [15:0] a, input int i);
    return {a[15:2], a[1:0] + 2'(i)};
  endfunction : bx
  function automatic logic [35:0] lm(input logic [3:0] l);
    return {{9{l[3]}}, {9{l[2]}}, {9{l[1]}}, {9{l[0]}}};
  endfunction : lm
  assign rd = rdp(ra);

  // Clock, stall source, watchdog
  initial forever #5 clk_sys_i = ~clk_sys_i;
  always @(negedge clk_sys_i) wr_ready_i <= hold ? 1'b0 : 1'($urandom);
  initial begin
    #100000;
    err_total++;
    close_out();
  end

  bsr_core i_bsr_core (.clk_sys_i, .rst_i, .in_clk_true_i(kt), .in_clk_comp_i(kc), .out_clk_true_i(okt),
    .out_clk_comp_i(okc), .cycle_load_n_i(ld_n), .read_nwrite_i(rnw), .addr_i(addr), .lane_sel_n_i(sel_n),
    .dq_i(dq_w), .dq_o(dq_r), .dq_oe_n_o(oe_n), .wr_valid_o(wv), .wr_ready_i, .wr_beat_o(wb),
    .rd_addr_o(ra), .rd_req_o(rreq), .rd_data_i(rd), .wr_overflow_o(ovf));
  bsr_ctl_model u_ctl (.k_o(kt), .kc_o(kc), .ok_o(okt), .okc_o(okc), .ld_n_o(ld_n), .rnw_o(rnw),
    .a_o(addr), .sel_o(sel_n), .dq_o(dq_w), .q_i(dq_r));

  task automatic chk(input logic [63:0] got, input logic [63:0] want);
    checks++;
    if (got !== want) begin
      err_total++;
      $display("Error at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk

  task automatic close_out();
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  // One random burst with corner overrides
  task automatic run(input int n);
    logic [15:0] a;
    logic [3:0][3:0] s;
    logic [3:0][35:0] d, q;
    logic r;
    a = 16'($urandom);
    r = n[0] & !flush;
    for (int i = 0; i < 4; i++) begin
      s[i] = 4'($urandom);
      d[i] = 36'({$urandom, $urandom});
    end
    if (n < 4) a[1:0] = 2'h3;
    if (n == 2) s = 16'hFFFF;
    if (n == 4) s = 16'h7BDE;
    if (flush) s = '0;
    for (int i = 0; i < 4; i++) if (!r && !flush && s[i] != 4'hF) exp.push_back({bx(a, i), ~s[i], d[i]});
    u_ctl.burst(r, a, 1'($urandom), s, d, q);
    for (int i = 0; i < 4; i++) if (r) chk(q[i], rdp(bx(a, i)));
  endtask : run

  // Write beat scoreboard
  always @(posedge clk_sys_i) begin
    if (!rst_i && wv && wr_ready_i) begin
      if (flush) ndrain++;
      else if (exp.size() == 0) chk(1, 0);
      else begin
        e = exp.pop_front();
        chk({wb.addr, wb.lane_en, wb.data & lm(e.lane_en)}, {e.addr, e.lane_en, e.data & lm(e.lane_en)});
      end
    end
  end

  // Main sequence
  initial begin
    void'($urandom(83047));
    repeat (8) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_i = 1'b0;
    chk(oe_n, 1'b1);
    repeat (3) @(posedge clk_sys_i);
    for (int n = 0; n < 30; n++) run(n);
    repeat (40) @(posedge clk_sys_i);
    chk(exp.size(), 0);
    hold = 1'b1;
    flush = 1'b1;
    for (int n = 30; n < 36; n++) run(n);
    chk(ovf, 1'b1);
    hold = 1'b0;
    repeat (100) @(posedge clk_sys_i);
    chk(ndrain, BSR_FIFO_DEPTH + 1); // Storage plus the registered output word
    close_out();
  end
endmodule : bsr_core_bench
`default_nettype wire

// ### dv/bsr_core_props.sv
`timescale 1ns/1ps
`default_nettype none
module bsr_core_props
  import bsr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Watched ports
  input wire logic wr_ready_i,
  input wire logic [BSR_DQ_W-1:0] dq_o,
  input wire logic dq_oe_n_o,
  input wire logic wr_valid_o,
  input wire bsr_wbeat_type wr_beat_o,
  input wire logic [BSR_ADDR_W-1:0] rd_addr_o,
  input wire logic rd_req_o,
  input wire logic wr_overflow_o
);
  logic [BSR_ADDR_W-1:0] prev_addr;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // Beat address one cycle back
  always_ff @(posedge clk_sys_i) prev_addr <= rd_addr_o;

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  oe_reset_a: assert property (disable iff (1'b0) rst_i |=> dq_oe_n_o && !wr_valid_o && dq_o == '0)
    else $error("outputs not idle after reset");
  oe_read_a: assert property ($fell(dq_oe_n_o) |-> rd_req_o)
    else $error("data driven outside read");
  oe_release_a: assert property ($fell(rd_req_o) |-> ##[0:2] dq_oe_n_o)
    else $error("data still driven after read");
  read_len_a: assert property ($rose(rd_req_o) |-> ##[8:60] !rd_req_o)
    else $error("read cycle length wrong");
  addr_step_a: assert property (rd_req_o && $past(rd_req_o) && rd_addr_o != prev_addr |->
    rd_addr_o[1:0] == prev_addr[1:0] + 2'h1 && rd_addr_o[15:2] == prev_addr[15:2])
    else $error("burst address not linear");
  dq_hold_a: assert property ($changed(dq_o) |-> !dq_oe_n_o)
    else $error("read data moved while idle");
  beat_hold_a: assert property (wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_beat_o))
    else $error("write beat dropped under stall");
  lane_live_a: assert property (wr_valid_o |-> wr_beat_o.lane_en != 4'h0)
    else $error("empty write beat pushed");
  ovf_sticky_a: assert property (wr_overflow_o |=> wr_overflow_o)
    else $error("overflow flag cleared");

  // Main scenarios
  cover property ($rose(rd_req_o));
  cover property (wr_valid_o && wr_ready_i);
  cover property ($rose(wr_overflow_o));
endmodule : bsr_core_props

bind bsr_core bsr_core_props u_props (.clk_sys_i, .rst_i, .wr_ready_i, .dq_o, .dq_oe_n_o, .wr_valid_o,
  .wr_beat_o, .rd_addr_o, .rd_req_o, .wr_overflow_o);
`default_nettype wire

// ### dv/bsr_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module bsr_ctl_model (
  // Link clocks
  output logic k_o,
  output logic kc_o,
  output logic ok_o,
  output logic okc_o,
  // Link controls and data
  output logic ld_n_o,
  output logic rnw_o,
  output logic [15:0] a_o,
  output logic [3:0] sel_o,
  output logic [35:0] dq_o,
  // Read data from device
  input wire logic [35:0] q_i
);
  // Parked link, no load
  initial begin
    {k_o, kc_o, ok_o, okc_o, rnw_o, a_o, sel_o, dq_o} = '0;
    ld_n_o = 1'b1;
  end

  // Load edge, then four beats on the next alternating edges, one trailing edge
  task automatic burst(input logic rd, input logic [15:0] a, input logic ob, input logic [3:0][3:0] s,
      input logic [3:0][35:0] d, output logic [3:0][35:0] q);
    {ld_n_o, rnw_o, a_o} = {1'b0, rd, a};
    {ok_o, okc_o} = {ob, ob};
    {sel_o, dq_o} = ~{sel_o, dq_o};
    #12.5;
    for (int e = 0; e < 6; e++) begin
      {k_o, kc_o} = {!e[0], e[0]};
      if (!ob) {ok_o, okc_o} = {!e[0], e[0]};
      #49;
      if (e > 0 && e < 5) q[e-1] = q_i;
      #1;
      {ld_n_o, a_o} = {1'b1, ~a};
      {sel_o, dq_o} = (e < 4) ? {s[e], d[e]} : ~{sel_o, dq_o};
      #12.5;
    end
    {k_o, kc_o, ok_o, okc_o} = 4'h0;
    #62.5;
  endtask : burst
endmodule : bsr_ctl_model
`default_nettype wire

// ### rtl/bsr_core.sv
`timescale 1ns/1ps
`default_nettype none
module bsr_core
  import bsr_pkg::*;
#(
  parameter logic [2:0] ORG = bsr_pkg::BSR_ORG_X36,
  parameter int FIFO_DEPTH = bsr_pkg::BSR_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Link clocks
  input wire logic in_clk_true_i,
  input wire logic in_clk_comp_i,
  input wire logic out_clk_true_i,
  input wire logic out_clk_comp_i,
  // Link controls
  input wire logic cycle_load_n_i,
  input wire logic read_nwrite_i,
  input wire logic [bsr_pkg::BSR_ADDR_W-1:0] addr_i,
  input wire logic [bsr_pkg::BSR_MAX_LANES-1:0] lane_sel_n_i,
  // Data pins
  input wire logic [bsr_pkg::BSR_DQ_W-1:0] dq_i,
  output logic [bsr_pkg::BSR_DQ_W-1:0] dq_o,
  output logic dq_oe_n_o,
  // Write stream to array
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  output bsr_pkg::bsr_wbeat_type wr_beat_o,
  // Read port from array
  output logic [bsr_pkg::BSR_ADDR_W-1:0] rd_addr_o,
  output logic rd_req_o,
  input wire logic [bsr_pkg::BSR_DQ_W-1:0] rd_data_i,
  // Status
  output logic wr_overflow_o
);
  import bsr_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam int SW = 4 + 2 + BSR_ADDR_W + BSR_MAX_LANES + BSR_DQ_W;

  logic [SW-1:0] sync_a;
  logic [SW-1:0] sync_b;
  logic [3:0] clk_prev;
  logic ikt;
  logic ikc;
  logic okt;
  logic okc;
  logic k_rise;
  logic kc_rise;
  logic ok_rise;
  logic okc_rise;
  logic [BSR_DQ_W-1:0] dq_s;
  logic [BSR_MAX_LANES-1:0] sel_n_s;
  bsr_ctrl_type ctrl_s;

  // Two flip-flop synchroniser on every link pin
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {in_clk_true_i, in_clk_comp_i, out_clk_true_i, out_clk_comp_i,
                 cycle_load_n_i, read_nwrite_i, addr_i, lane_sel_n_i, dq_i};
      sync_b <= sync_a;
    end
  end

  // Unpack synchronised pins
  assign {ikt, ikc, okt, okc} = sync_b[SW-1 -: 4];
  assign ctrl_s = sync_b[SW-5 -: (2 + BSR_ADDR_W)];
  assign sel_n_s = sync_b[BSR_DQ_W +: BSR_MAX_LANES];
  assign dq_s = sync_b[BSR_DQ_W-1:0];

  // Previous clock levels for edge finding
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      clk_prev <= 4'hF;
    end else begin
      clk_prev <= {ikt, ikc, okt, okc};
    end
  end

  // Rising edge detectors
  assign k_rise = ikt && !clk_prev[3];
  assign kc_rise = ikc && !clk_prev[2];
  assign ok_rise = okt && !clk_prev[1];
  assign okc_rise = okc && !clk_prev[0];

  // ----------------------------------------
  // Bus cycle state machine
  // ----------------------------------------
  bsr_state_type state;
  bsr_state_type next_state;
  logic [1:0] beat;
  logic [BSR_ADDR_W-1:0] base_addr;
  logic [1:0] next_beat;
  logic load_now;
  logic last_beat;
  logic wr_edge;
  logic rd_edge;
  logic burst_edge;

  // Controls taken only at true input clock edge
  assign load_now = k_rise && !ctrl_s.load_n;
  assign wr_edge = (state == BSR_WRITE) && (k_rise || kc_rise);
  assign burst_edge = (state == BSR_WRITE) ? wr_edge : rd_edge;
  assign last_beat = (beat == 2'(BSR_BURST_LEN - 1));
  assign next_beat = beat + 2'h1;

  // Next state from load and read/write level
  always_comb begin
    next_state = state;
    if (state == BSR_IDLE) begin
      if (load_now) begin
        next_state = ctrl_s.read_nwrite ? BSR_READ : BSR_WRITE;
      end
    end else if (burst_edge && last_beat) begin
      next_state = BSR_IDLE;
    end
  end

  // State, beat counter and captured base address
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state <= BSR_IDLE;
      beat <= BSR_BEAT_RST;
      base_addr <= '0;
    end else begin
      state <= next_state;
      if (state == BSR_IDLE && load_now) begin
        beat <= BSR_BEAT_RST;
        base_addr <= ctrl_s.addr;
      end else if (burst_edge) begin
        beat <= next_beat;
      end
    end
  end

  // Linear burst address: low two bits advance
  logic [BSR_ADDR_W-1:0] beat_addr;
  assign beat_addr = {base_addr[BSR_ADDR_W-1:2], base_addr[1:0] + beat};

  // ----------------------------------------
  // Write lane masks
  // ----------------------------------------
  logic [BSR_MAX_LANES-1:0] lane_en;
  logic [BSR_DQ_W-1:0] bit_en;

  // Per organisation select to lane mapping
  always_comb begin
    lane_en = '0;
    unique case (ORG)
      BSR_ORG_X8: lane_en = {2'h0, ~sel_n_s[1:0]};
      BSR_ORG_X9: lane_en = {3'h0, ~sel_n_s[0]};
      BSR_ORG_X18: lane_en = {2'h0, ~sel_n_s[1:0]};
      default: lane_en = ~sel_n_s;
    endcase
  end

  // Bit enables; x8 lanes are nibbles of DQ0-7
  genvar gi;
  generate
    for (gi = 0; gi < BSR_DQ_W; gi++) begin : g_bit
      if (ORG == BSR_ORG_X8) begin : g_nib
        assign bit_en[gi] = (gi < 8) ? lane_en[gi / 4] : 1'b0;
      end else if (ORG == BSR_ORG_X9) begin : g_x9
        assign bit_en[gi] = (gi < 9) ? lane_en[0] : 1'b0;
      end else begin : g_lane
        assign bit_en[gi] = lane_en[gi / BSR_LANE_BITS];
      end
    end
  endgenerate

  // ----------------------------------------
  // Write beat FIFO
  // ----------------------------------------
  bsr_wbeat_type fifo_in;
  logic fifo_ready;
  logic fifo_push;

  // Masks only count during a write cycle
  assign fifo_in.addr = beat_addr;
  assign fifo_in.lane_en = lane_en;
  assign fifo_in.data = dq_s & bit_en;
  assign fifo_push = wr_edge && (lane_en != '0);

  bsr_fifo #(
    .WIDTH($bits(bsr_wbeat_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_ready),
    .in_data_i(fifo_in),
    .out_valid_o(wr_valid_o),
    .out_ready_i(wr_ready_i),
    .out_data_o(wr_beat_o)
  );

  // Sticky flag: a beat arrived while the FIFO was full
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_overflow_o <= 1'b0;
    end else if (fifo_push && !fifo_ready) begin
      wr_overflow_o <= 1'b1;
    end
  end

  // ----------------------------------------
  // Read launch
  // ----------------------------------------
  logic use_in_clk;
  logic dq_oe_n;

  // Both output clocks high selects input clocks
  assign use_in_clk = okt && okc;
  assign rd_edge = (state == BSR_READ) &&
                   (use_in_clk ? (k_rise || kc_rise) : (ok_rise || okc_rise));
  assign rd_addr_o = beat_addr;
  assign rd_req_o = (state == BSR_READ);

  // Output data register and enable
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      dq_o <= '0;
      dq_oe_n <= 1'b1;
    end else if (rd_edge) begin
      dq_o <= rd_data_i;
      dq_oe_n <= 1'b0;
    end else if (state == BSR_IDLE) begin
      dq_oe_n <= 1'b1;
    end
  end

  assign dq_oe_n_o = dq_oe_n;
endmodule : bsr_core
`default_nettype wire

// ### rtl/bsr_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module bsr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] count;
  logic full;
  logic empty;
  logic do_wr;
  logic do_rd;

  // Status and strobes; read data register reloads when it drains
  assign count = wr_ptr - rd_ptr;
  assign full = (count == (AW+1)'(DEPTH));
  assign empty = (count == '0);
  assign in_ready_o = !full;
  assign do_wr = in_valid_i && !full;
  assign do_rd = !empty && (!out_valid_o || out_ready_i);

  // Storage
  always_ff @(posedge clk_sys_i) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  // Pointers and registered output
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
        out_data_o <= mem[rd_ptr[AW-1:0]];
        out_valid_o <= 1'b1;
      end else if (out_ready_i) begin
        out_valid_o <= 1'b0;
      end
    end
  end
endmodule : bsr_fifo
`default_nettype wire

// ### rtl/bsr_pkg.sv
package bsr_pkg;

  // ----------------------------------------
  // Organisation and sizes
  // ----------------------------------------
  localparam int BSR_LANE_BITS = 9;
  localparam int BSR_MAX_LANES = 4;
  localparam int BSR_DQ_W = BSR_LANE_BITS * BSR_MAX_LANES;
  localparam int BSR_ADDR_W = 16;
  localparam int BSR_BURST_LEN = 4;
  localparam int BSR_FIFO_DEPTH = 16;
  localparam logic [2:0] BSR_ORG_X8 = 3'h0;
  localparam logic [2:0] BSR_ORG_X9 = 3'h1;
  localparam logic [2:0] BSR_ORG_X18 = 3'h2;
  localparam logic [2:0] BSR_ORG_X36 = 3'h3;
  localparam logic [1:0] BSR_BEAT_RST = 2'h0;
  localparam logic [BSR_MAX_LANES-1:0] BSR_SEL_IDLE = 4'hF;

  // ----------------------------------------
  // Bus cycle states (Gray along idle-read-write; idle to write flips both bits)
  // ----------------------------------------
  typedef enum logic [1:0] {
    BSR_IDLE = 2'b00,
    BSR_READ = 2'b01,
    BSR_WRITE = 2'b11
  } bsr_state_type;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic load_n;
    logic read_nwrite;
    logic [BSR_ADDR_W-1:0] addr;
  } bsr_ctrl_type;

  typedef struct packed {
    logic [BSR_ADDR_W-1:0] addr;
    logic [BSR_MAX_LANES-1:0] lane_en;
    logic [BSR_DQ_W-1:0] data;
  } bsr_wbeat_type;

endpackage : bsr_pkg
